//--- src/conv_opt_pkg.sv
// Types shared by the converter option logic.
// Assumes the constants header is on the include path.
package conv_opt_pkg;
    `include "conv_opt_regs.svh"

    // State of the low-side switch hold after an output overvoltage fault.
    typedef enum logic {lowside_released, lowside_held} lowside_state_type;

    // Two-bit overcurrent trim code.
    typedef logic [1:0] trim_code_type;
endpackage

//--- src/conv_opt_regs.svh
// Command codes, field positions and reset values of the converter option registers.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CONV_OPT_REGS_SVH
`define CONV_OPT_REGS_SVH

// Command codes of the two option registers.
`define OPT_CMD             8'he5
`define MISC_CMD            8'hf0

// User options register layout and reset value.
`define OPT_RESET           16'h00c7
`define OPT_WMASK           16'h01ff
`define OPT_AUTO_ALERT_BIT  7
`define OPT_SOFTSTART_OFF_BIT 8

// Miscellaneous configuration register layout and reset value.
`define MISC_RESET          16'h0003
`define MISC_WMASK          16'h000f
`define MISC_OV_SEL_BIT     0
`define MISC_TRIM_LSB       1
`define MISC_TRIM_MSB       2
`define MISC_FORCE_SYNC_BIT 3

// Fixed temperature report, 25 degrees Celsius in whole degrees.
`define TEMP_FIXED          16'h0019

// Overcurrent threshold multipliers in eighths for each trim code.
`define TRIM_MULT_NONE      4'h8
`define TRIM_MULT_UP_12     4'h9
`define TRIM_MULT_DN_25     4'h6
`define TRIM_MULT_DN_12     4'h7

// Number of fault sources that can raise the alert line.
`define FAULT_SOURCES       8

`endif

//--- src/converter_option_config.sv
// Option and miscellaneous configuration registers of the converter management interface.
// Assumes a same-clock command decoder drives the register port and pins reach here unsynchronised.
`include "conv_opt_regs.svh"
module converter_option_config
(
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    input  wire logic [7:0]                          reg_cmd,
    input  wire logic [15:0]                         reg_wdata,
    output logic      [15:0]                         reg_rdata,
    output logic                                     reg_ack,
    output logic                                     reg_err,
    input  wire logic [`FAULT_SOURCES-1:0]           fault_status,
    input  wire logic [`FAULT_SOURCES-1:0]           host_mask,
    input  wire logic                                ara_done,
    input  wire logic                                clear_faults,
    output logic      [`FAULT_SOURCES-1:0]           auto_mask,
    output logic                                     alert,
    input  wire logic [15:0]                         ext_temp,
    output logic      [15:0]                         temp_report,
    input  wire logic                                store_all,
    output logic                                     nvm_store,
    output logic      [15:0]                         nvm_options,
    output logic      [15:0]                         nvm_misc,
    input  wire logic                                ov_fault,
    input  wire logic                                ov_resp_ignore,
    input  wire logic                                startup_begin,
    input  wire logic                                state_disabled,
    input  wire logic                                below_uv_pin,
    output logic                                     lowside_on,
    input  wire logic [7:0]                          hs_base,
    output logic      [8:0]                          hs_threshold,
    input  wire logic                                strap_valid,
    input  wire logic                                sync_reset_pin,
    output logic                                     pin_is_reset,
    output logic                                     reset_req_n,
    output logic                                     sync_clk
);
    import conv_opt_pkg::*;

    logic [15:0]                options;
    logic [15:0]                misc;
    logic [15:0]                next_options;
    logic [15:0]                next_misc;
    logic [15:0]                next_rdata;
    logic                       next_ack;
    logic                       next_err;
    logic [`FAULT_SOURCES-1:0]  next_auto_mask;
    logic                       next_alert;
    logic [15:0]                next_temp;
    logic                       next_nvm_store;
    logic [15:0]                next_nvm_options;
    logic [15:0]                next_nvm_misc;
    logic [8:0]                 next_threshold;
    logic                       next_pin_is_reset;
    logic                       next_reset_req_n;
    logic                       next_sync_clk;
    logic [3:0]                 trim_mult;
    logic [11:0]                trim_product;
    trim_code_type              trim_code;
    logic [1:0]                 pin_meta;
    logic [1:0]                 pin_sync;

    // Two-stage synchronisers: bit 0 the shared pin, bit 1 the undervoltage comparator.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 2'h3;
            pin_sync <= 2'h3;
        end
        else
        begin
            pin_meta <= {below_uv_pin, sync_reset_pin};
            pin_sync <= pin_meta;
        end
    end

    // Register file: writes through the write mask, reads with answer next cycle.
    always_comb
    begin
        next_options     = options;
        next_misc        = misc;
        next_rdata       = 16'h0000;
        next_ack         = reg_wr || reg_rd;
        next_err         = 1'b0;
        next_nvm_store   = store_all;
        next_nvm_options = nvm_options;
        next_nvm_misc    = nvm_misc;
        if (reg_wr)
        begin
            if (reg_cmd == `OPT_CMD)
                next_options = reg_wdata & `OPT_WMASK;
            else if (reg_cmd == `MISC_CMD)
                next_misc = reg_wdata & `MISC_WMASK;
            else
                next_err = 1'b1;
        end
        else if (reg_rd)
        begin
            if (reg_cmd == `OPT_CMD)
                next_rdata = options;
            else if (reg_cmd == `MISC_CMD)
                next_rdata = misc;
            else
                next_err = 1'b1;
        end
        if (store_all)
        begin
            next_nvm_options = options;
            next_nvm_misc    = misc;
        end
    end

    // Registers the register file state and its answers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            options     <= `OPT_RESET;
            misc        <= `MISC_RESET;
            reg_rdata   <= 16'h0000;
            reg_ack     <= 1'b0;
            reg_err     <= 1'b0;
            nvm_store   <= 1'b0;
            nvm_options <= `OPT_RESET;
            nvm_misc    <= `MISC_RESET;
        end
        else
        begin
            options     <= next_options;
            misc        <= next_misc;
            reg_rdata   <= next_rdata;
            reg_ack     <= next_ack;
            reg_err     <= next_err;
            nvm_store   <= next_nvm_store;
            nvm_options <= next_nvm_options;
            nvm_misc    <= next_nvm_misc;
        end
    end

    // Trim multiplier in eighths of the base overcurrent threshold.
    assign trim_code = misc[`MISC_TRIM_MSB:`MISC_TRIM_LSB];
    always_comb
    begin
        unique case (trim_code)
            2'h0: trim_mult = `TRIM_MULT_NONE;
            2'h1: trim_mult = `TRIM_MULT_UP_12;
            2'h2: trim_mult = `TRIM_MULT_DN_25;
            2'h3: trim_mult = `TRIM_MULT_DN_12;
        endcase
    end
    assign trim_product = 12'(hs_base) * 12'(trim_mult);

    // Functional outputs: alert masking, temperature, threshold and pin routing.
    always_comb
    begin
        next_auto_mask = auto_mask & ~{`FAULT_SOURCES{clear_faults}};
        if (ara_done && options[`OPT_AUTO_ALERT_BIT])
            next_auto_mask = next_auto_mask | fault_status;
        next_alert = |(fault_status & ~host_mask & ~auto_mask);
        next_temp = options[`OPT_SOFTSTART_OFF_BIT] ? ext_temp : `TEMP_FIXED;
        next_threshold = trim_product[11:3];
        next_pin_is_reset = !misc[`MISC_FORCE_SYNC_BIT] && strap_valid;
        next_reset_req_n = pin_is_reset ? pin_sync[0] : 1'b1;
        next_sync_clk = pin_is_reset ? 1'b0 : pin_sync[0];
    end

    // Registers the functional outputs.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_mask    <= '0;
            alert        <= 1'b0;
            temp_report  <= `TEMP_FIXED;
            hs_threshold <= 9'h000;
            pin_is_reset <= 1'b0;
            reset_req_n  <= 1'b1;
            sync_clk     <= 1'b0;
        end
        else
        begin
            auto_mask    <= next_auto_mask;
            alert        <= next_alert;
            temp_report  <= next_temp;
            hs_threshold <= next_threshold;
            pin_is_reset <= next_pin_is_reset;
            reset_req_n  <= next_reset_req_n;
            sync_clk     <= next_sync_clk;
        end
    end

    // Overvoltage low-side hold; its state flop drives the output directly.
    ov_release u_ov_release
    (
        .clk            (clk),
        .rst_n          (rst_n),
        .ov_fault       (ov_fault),
        .ov_resp_ignore (ov_resp_ignore),
        .release_select (misc[`MISC_OV_SEL_BIT]),
        .startup_begin  (startup_begin),
        .clear_faults   (clear_faults),
        .state_disabled (state_disabled),
        .below_uv       (pin_sync[1]),
        .lowside_on     (lowside_on)
    );

    AST_AUTO_MASK: assert property (@(posedge clk) disable iff (!rst_n)
        ara_done && options[`OPT_AUTO_ALERT_BIT]
        |=> ((auto_mask & $past(fault_status)) == $past(fault_status)))
        else $error("Auto mask did not cover faults set at alert response.");

    AST_NO_AUTO_MASK: assert property (@(posedge clk) disable iff (!rst_n)
        ara_done && !options[`OPT_AUTO_ALERT_BIT] && !clear_faults |=> auto_mask == $past(auto_mask))
        else $error("Auto mask changed while automatic masking is off.");

    AST_ALERT_PERSIST: assert property (@(posedge clk) disable iff (!rst_n)
        |(fault_status & ~host_mask & ~auto_mask) |=> alert)
        else $error("Unmasked persistent fault did not raise the alert.");

    AST_TEMP_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
        !options[`OPT_SOFTSTART_OFF_BIT] |=> temp_report == `TEMP_FIXED)
        else $error("Temperature not fixed while pin sets soft start.");

    AST_STORE: assert property (@(posedge clk) disable iff (!rst_n)
        store_all |=> nvm_store && nvm_misc == $past(misc) && nvm_options == $past(options))
        else $error("Store command did not copy configuration.");

    AST_TRIM_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
        trim_code == 2'h2 |=> hs_threshold == 9'((12'($past(hs_base)) * 12'(`TRIM_MULT_DN_25)) >> 3))
        else $error("Minus 25 percent trim gave the wrong threshold.");

    AST_PIN_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        !misc[`MISC_FORCE_SYNC_BIT] && strap_valid |=> pin_is_reset)
        else $error("Shared pin not used as reset with valid strap.");

    AST_PIN_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
        misc[`MISC_FORCE_SYNC_BIT] |=> !pin_is_reset ##1 reset_req_n)
        else $error("Shared pin not used as sync while override is set.");

    AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_cmd == `MISC_CMD |=> reg_ack && reg_rdata[15:4] == 12'h000)
        else $error("Reserved bits of miscellaneous register read nonzero.");
endmodule // converter_option_config

//--- src/ov_release.sv
// Low-side switch hold and release after an output overvoltage fault.
// Assumes same-clock fault and command pulses and an already synchronised comparator level.
module ov_release
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ov_fault,
    input  wire logic ov_resp_ignore,
    input  wire logic release_select,
    input  wire logic startup_begin,
    input  wire logic clear_faults,
    input  wire logic state_disabled,
    input  wire logic below_uv,
    output logic      lowside_on
);
    import conv_opt_pkg::*;

    lowside_state_type state;
    lowside_state_type next_state;

    // A new fault wins over any release in the same cycle.
    always_comb
    begin
        next_state = state;
        if (ov_fault && !ov_resp_ignore)
            next_state = lowside_held;
        else if (state == lowside_held)
        begin
            if (!release_select && (startup_begin || (clear_faults && state_disabled)))
                next_state = lowside_released;
            else if (release_select && below_uv)
                next_state = lowside_released;
        end
    end

    // Holds the state; the output is the state flop itself.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= lowside_released;
        else
            state <= next_state;
    end

    assign lowside_on = (state == lowside_held);

    AST_OV_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
        ov_fault && !ov_resp_ignore |=> lowside_on)
        else $error("Low-side switch not latched on after overvoltage fault.");

    AST_OV_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        lowside_on && !release_select && !ov_fault && !startup_begin && !(clear_faults && state_disabled)
        |=> lowside_on)
        else $error("Low-side switch released without startup or clear in disabled state.");

    AST_OV_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        lowside_on && release_select && below_uv && !ov_fault |=> !lowside_on)
        else $error("Low-side switch not released below undervoltage limit.");
endmodule // ov_release

//--- test/host_model.sv
// Host-side model that issues register commands and holds the per-source fault masks.
// Assumes the register port takes one pulse per access and answers one cycle later.
module host_model
(
    input  wire logic        clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_cmd,
    output logic [15:0]      reg_wdata,
    output logic [7:0]       host_mask,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_err
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle values at time zero, no source masked.
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_cmd   = 8'h00;
        reg_wdata = 16'h0000;
        host_mask = 8'h00;
    end

    // One access: request for one cycle, then the answer is taken in the acknowledge cycle.
    task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] data,
                          output logic [15:0] rdata, output logic ack, output logic err);
        @(posedge clk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_cmd   <= cmd;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~data; // Data no longer qualified, so it shows a changed pattern.
        #1;
        rdata = reg_rdata;
        ack   = reg_ack;
        err   = reg_err;
    endtask

    // The host masks persistent sources itself when automatic masking is off.
    task automatic set_mask(input logic [7:0] m);
        @(posedge clk);
        host_mask <= m;
    endtask
endmodule // host_model

//--- test/tb_converter_option_config.sv
// Self-checking bench of the converter option registers and their side logic.
// Assumes the host model drives the register port and masks; this module drives the rest.
`include "conv_opt_regs.svh"
module tb_converter_option_config;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_opt_pkg::*;

    logic clk = 1'b0, rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_ack, reg_err, ara_done = 0, clear_faults = 0, alert, store_all = 0;
    logic [7:0] reg_cmd, host_mask, fault_status = 0, auto_mask, hs_base = 8'h40;
    logic [15:0] reg_wdata, reg_rdata, ext_temp = 16'h0040, temp_report, nvm_options, nvm_misc;
    logic nvm_store, ov_fault = 0, ov_resp_ignore = 0, startup_begin = 0, state_disabled = 0;
    logic below_uv_pin = 0, lowside_on, strap_valid = 0, sync_reset_pin = 1;
    logic pin_is_reset, reset_req_n, sync_clk;
    logic [8:0] hs_threshold;
    logic [15:0] rd_d;
    logic rd_a, rd_e;
    int err_total = 0, samples_checked = 0, cycles = 0;

    // Clock of 10 ns period.
    always #5 clk = ~clk;

    host_model host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
        .reg_wdata(reg_wdata), .host_mask(host_mask), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err));

    converter_option_config converter_option_config_i (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .fault_status(fault_status), .host_mask(host_mask),
        .ara_done(ara_done), .clear_faults(clear_faults), .auto_mask(auto_mask), .alert(alert),
        .ext_temp(ext_temp), .temp_report(temp_report), .store_all(store_all),
        .nvm_store(nvm_store), .nvm_options(nvm_options), .nvm_misc(nvm_misc),
        .ov_fault(ov_fault), .ov_resp_ignore(ov_resp_ignore), .startup_begin(startup_begin),
        .state_disabled(state_disabled), .below_uv_pin(below_uv_pin), .lowside_on(lowside_on),
        .hs_base(hs_base), .hs_threshold(hs_threshold), .strap_valid(strap_valid),
        .sync_reset_pin(sync_reset_pin), .pin_is_reset(pin_is_reset),
        .reset_req_n(reset_req_n), .sync_clk(sync_clk));

    // Compares one value with its expectation and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Lets n edges pass and samples just after the last.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle pulse on a bench-driven strobe, chosen by number:
    // 0 alert response done, 1 clear faults, 2 store all, 3 overvoltage, 4 startup.
    task automatic pulse(input int which);
        logic level;
        level = 1'b1;
        repeat (2)
        begin
            @(posedge clk);
            case (which)
                0: ara_done <= level;
                1: clear_faults <= level;
                2: store_all <= level;
                3: ov_fault <= level;
                default: startup_begin <= level;
            endcase
            level = 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        host_model_i.access(1'b1, cmd, d, rd_d, rd_a, rd_e);
        check({15'h0, rd_a}, 16'h1, "write ack");
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp, input logic exp_err);
        host_model_i.access(1'b0, cmd, 16'h0, rd_d, rd_a, rd_e);
        check({15'h0, rd_a}, 16'h1, "read ack");
        check(rd_d, exp, "read data");
        check({15'h0, rd_e}, {15'h0, exp_err}, "read error");
    endtask

    // Reset values, unmapped access and reserved bits of the miscellaneous register.
    task automatic test_regs();
        rd_chk(`OPT_CMD, 16'h00c7, 1'b0);
        rd_chk(`MISC_CMD, 16'h0003, 1'b0);
        rd_chk(8'h42, 16'h0000, 1'b1);
        wr(`MISC_CMD, 16'hfff5);
        rd_chk(`MISC_CMD, 16'h0005, 1'b0);
        $display("test_regs done");
    endtask

    // Every trim code applied to a base threshold of 64.
    task automatic test_trim();
        logic [8:0] exp [4] = '{9'd64, 9'd72, 9'd48, 9'd56};
        for (int t = 0; t < 4; t++)
        begin
            wr(`MISC_CMD, 16'(t << 1));
            settle(2);
            check({7'h0, hs_threshold}, {7'h0, exp[t]}, "trim threshold");
        end
        $display("test_trim done");
    endtask

    // Automatic masking on and off after an alert response.
    task automatic test_alert();
        @(posedge clk);
        fault_status <= 8'h05;
        settle(3);
        check({15'h0, alert}, 16'h1, "alert raised");
        pulse(0);
        settle(3);
        check({8'h0, auto_mask}, 16'h0005, "auto mask set");
        check({15'h0, alert}, 16'h0, "alert masked");
        pulse(1);
        #1;
        check({8'h0, auto_mask}, 16'h0000, "auto mask cleared");
        wr(`OPT_CMD, 16'h0047);
        pulse(0);
        settle(3);
        check({8'h0, auto_mask}, 16'h0000, "no auto mask");
        check({15'h0, alert}, 16'h1, "alert persists");
        host_model_i.set_mask(8'h05);
        settle(3);
        check({15'h0, alert}, 16'h0, "host masked");
        host_model_i.set_mask(8'h00);
        fault_status <= 8'h00;
        $display("test_alert done");
    endtask

    // Fixed temperature while the pin sets soft start, then the copy to non-volatile memory.
    task automatic test_temp_store();
        settle(2);
        check(temp_report, `TEMP_FIXED, "fixed temperature");
        wr(`OPT_CMD, 16'h0147);
        settle(2);
        check(temp_report, 16'h0040, "measured temperature");
        wr(`MISC_CMD, 16'h0006);
        pulse(2);
        #1;
        check({15'h0, nvm_store}, 16'h1, "store pulse");
        check(nvm_misc, 16'h0006, "stored misc");
        check(nvm_options, 16'h0147, "stored options");
        $display("test_temp_store done");
    endtask

    // Low-side hold and both release policies, plus the ignore response.
    task automatic test_lowside();
        wr(`MISC_CMD, 16'h0001);
        pulse(3);
        settle(1);
        check({15'h0, lowside_on}, 16'h1, "latched on");
        @(posedge clk);
        below_uv_pin <= 1'b1;
        settle(5);
        check({15'h0, lowside_on}, 16'h0, "released below limit");
        wr(`MISC_CMD, 16'h0000);
        pulse(3);
        pulse(1);
        settle(3);
        check({15'h0, lowside_on}, 16'h1, "held while enabled");
        @(posedge clk);
        state_disabled <= 1'b1;
        pulse(1);
        settle(2);
        check({15'h0, lowside_on}, 16'h0, "clear while disabled");
        @(posedge clk);
        state_disabled <= 1'b0;
        pulse(3);
        #1;
        check({15'h0, lowside_on}, 16'h1, "latched before startup");
        pulse(4);
        settle(2);
        check({15'h0, lowside_on}, 16'h0, "startup release");
        @(posedge clk);
        ov_resp_ignore <= 1'b1;
        pulse(3);
        settle(2);
        check({15'h0, lowside_on}, 16'h0, "ignore response");
        @(posedge clk);
        ov_resp_ignore <= 1'b0;
        below_uv_pin <= 1'b0;
        $display("test_lowside done");
    endtask

    // Shared pin function with and without the override.
    task automatic test_pin();
        @(posedge clk);
        strap_valid <= 1'b1;
        sync_reset_pin <= 1'b0;
        settle(5);
        check({14'h0, pin_is_reset, reset_req_n}, 16'h2, "pin as reset");
        @(posedge clk);
        strap_valid <= 1'b0;
        settle(5);
        check({14'h0, pin_is_reset, sync_clk}, 16'h0, "pin as sync");
        wr(`MISC_CMD, 16'h0008);
        @(posedge clk);
        strap_valid <= 1'b1;
        sync_reset_pin <= 1'b1;
        settle(5);
        check({14'h0, pin_is_reset, sync_clk}, 16'h1, "forced sync");
        check({15'h0, reset_req_n}, 16'h1, "no reset request");
        $display("test_pin done");
    endtask

    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_trim();
        test_alert();
        test_temp_store();
        test_lowside();
        test_pin();
        tally_and_finish();
    end
endmodule // tb_converter_option_config
